// file: csu_defines.vh
// Constants for the conditional skip unit: operation codes, flag bit
// positions, register offsets and reset values.
// Assumes inclusion by bare name from every file of the unit.
`ifndef CSU_DEFINES_VH
`define CSU_DEFINES_VH

////////////////////////////////////////////////////////////////////////
// Operation codes on insn_op
`define CSU_OP_CEQ_IMM 4'h0
`define CSU_OP_CEQ_MEM 4'h1
`define CSU_OP_CNE_MEM 4'h2
`define CSU_OP_CNE_IMM 4'h3
`define CSU_OP_TLO_IO 4'h4
`define CSU_OP_THI_IO 4'h5
`define CSU_OP_TLO_MEM 4'h6
`define CSU_OP_THI_MEM 4'h7
`define CSU_OP_INC_WR 4'h8
`define CSU_OP_DEC_WR 4'h9
`define CSU_OP_INC_MEM 4'ha
`define CSU_OP_DEC_MEM 4'hb

////////////////////////////////////////////////////////////////////////
// Flag bit positions
`define CSU_FLAG_ZERO 0
`define CSU_FLAG_CARRY 1
`define CSU_FLAG_NIBBLE 2
`define CSU_FLAG_WRAP 3

////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define CSU_REG_CTRL 8'h00
`define CSU_REG_WORK 8'h04
`define CSU_REG_FLAGS 8'h08
`define CSU_REG_STATUS 8'h0c

// Control fields
`define CSU_CTRL_ENABLE 0
`define CSU_CTRL_CNT_CLR 1

////////////////////////////////////////////////////////////////////////
// Reset values
`define CSU_RST_CTRL 2'h1
`define CSU_RST_WORK 8'h00
`define CSU_RST_FLAGS 4'h0

`endif

// file: csu_arith.v
// Eight-bit adder/subtractor producing zero, carry/borrow, nibble carry
// and signed wrap flags. Purely combinational.
`timescale 1ns/1ps
`include "csu_defines.vh"

module csu_arith
(
  input wire [7:0] opa,
  input wire [7:0] opb,
  input wire sub,
  output wire [7:0] result,
  output wire [3:0] flags
);

  wire [8:0] full;
  wire [4:0] low;
  wire wrap;

  // Borrow on subtract, carry on add
  assign full = sub ? ({1'b0, opa} - {1'b0, opb})
                    : ({1'b0, opa} + {1'b0, opb});
  assign low = sub ? ({1'b0, opa[3:0]} - {1'b0, opb[3:0]})
                   : ({1'b0, opa[3:0]} + {1'b0, opb[3:0]});
  assign result = full[7:0];
  assign wrap = sub ? ((opa[7] ^ opb[7]) & (full[7] ^ opa[7]))
                    : (~(opa[7] ^ opb[7]) & (full[7] ^ opa[7]));

  assign flags[`CSU_FLAG_ZERO] = (full[7:0] == 8'h00);
  assign flags[`CSU_FLAG_CARRY] = full[8];
  assign flags[`CSU_FLAG_NIBBLE] = low[4];
  assign flags[`CSU_FLAG_WRAP] = wrap;

endmodule // csu_arith

// file: csu_wb_slave.v
// Classic Wishbone slave front end: one-wait-state ack, word decode and
// read mux. Register storage lives in the parent.
// Assumes a master that holds the request until ack.
`timescale 1ns/1ps
`include "csu_defines.vh"

module csu_wb_slave
(
  input wire clock,
  input wire rstn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  output wire wb_ack_o,
  output reg [31:0] wb_dat_o,
  input wire [1:0] ctrl_q,
  input wire [7:0] work_q,
  input wire [3:0] flags_q,
  input wire [15:0] status_q,
  output wire wr_ctrl,
  output wire wr_work,
  output wire wr_flags
);

  reg ack_ff;
  wire nxt_ack;
  wire take;
  wire wr0;

  assign nxt_ack = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign take = nxt_ack;
  // Writes land on the edge where the master sees ack
  assign wr0 = ack_ff & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
  assign wb_ack_o = ack_ff;

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      ack_ff <= 1'b0;
    else
      ack_ff <= nxt_ack;
  end

  assign wr_ctrl = wr0 & (wb_adr_i == `CSU_REG_CTRL);
  assign wr_work = wr0 & (wb_adr_i == `CSU_REG_WORK);
  assign wr_flags = wr0 & (wb_adr_i == `CSU_REG_FLAGS);

  // Read data registered alongside ack; unmapped reads return zero
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      wb_dat_o <= 32'h0000_0000;
    else if (take && !wb_we_i)
    begin
      if (wb_adr_i == `CSU_REG_CTRL)
        wb_dat_o <= {30'h0000_0000, ctrl_q};
      else if (wb_adr_i == `CSU_REG_WORK)
        wb_dat_o <= {24'h00_0000, work_q};
      else if (wb_adr_i == `CSU_REG_FLAGS)
        wb_dat_o <= {28'h000_0000, flags_q};
      else if (wb_adr_i == `CSU_REG_STATUS)
        wb_dat_o <= {16'h0000, status_q};
      else
        wb_dat_o <= 32'h0000_0000;
    end
  end

endmodule // csu_wb_slave

// file: csu_skip_unit.v
// Conditional skip unit: executes compare-skip, bit-test-skip and
// increment/decrement-skip operations, owns the working register and
// the four arithmetic flags, and suppresses the instruction that follows
// a taken skip.
// Assumes a sequencer that presents one decoded operation per insn_valid
// pulse with memory and port bytes valid in the same cycle.
//
// What this block does
// - Equal immediate compare skips next instruction.
// - Equal memory compare skips next instruction.
// - Unequal memory compare skips next instruction.
// - Unequal immediate compare skips next instruction.
// - Compares set flags like subtraction.
// - Port bit tests skip, flags untouched.
// - Port bit high causes high-test skip.
// - Memory bit tests skip, flags untouched.
// - Increment working register, skip on zero.
// - Decrement working register, skip on zero.
// - Increment memory byte, skip on zero.
// - Decrement memory byte, skip on zero.
`timescale 1ns/1ps
`include "csu_defines.vh"

module csu_skip_unit
#(
  parameter WIDTH = 8
)
(
  input wire clock,
  input wire rstn,
  // Decoded operation from the sequencer
  input wire insn_valid,
  input wire [3:0] insn_op,
  input wire [7:0] insn_imm,
  input wire [2:0] insn_bit,
  input wire [7:0] mem_rdata,
  input wire [7:0] port_rdata,
  // Results
  output wire insn_squash,
  output wire skip_pending,
  output reg mem_we_ff,
  output reg [7:0] mem_wdata_ff,
  output wire [7:0] working_register,
  output wire [3:0] flags,
  // Wishbone
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire wb_ack_o,
  output wire [31:0] wb_dat_o
);

  ////////////////////////////////////////////////////////////////////////
  // State
  localparam ST_RUN = 2'b01;
  localparam ST_SKIP = 2'b10;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [7:0] work_ff;
  reg [7:0] nxt_work;
  reg [3:0] flags_ff;
  reg [3:0] nxt_flags;
  reg [1:0] ctrl_ff;
  reg [1:0] nxt_ctrl;
  reg [7:0] skip_cnt_ff;
  reg [7:0] nxt_skip_cnt;
  // Write-back pulse and data toward the data memory
  reg nxt_mem_we;
  reg [7:0] nxt_mem_wdata;

  ////////////////////////////////////////////////////////////////////////
  // Operation decode
  wire enabled;
  wire live;
  wire is_cmp;
  wire is_imm;
  wire is_test;
  wire is_step;
  wire step_mem;
  wire step_dec;
  wire test_io;
  wire test_high;
  wire [7:0] cmp_operand;
  wire [7:0] test_byte;
  wire test_bit;

  assign enabled = ctrl_ff[`CSU_CTRL_ENABLE];
  // A suppressed instruction never reaches execution
  assign live = insn_valid & enabled & (state_ff == ST_RUN);

  assign is_cmp = (insn_op == `CSU_OP_CEQ_IMM) |
                  (insn_op == `CSU_OP_CEQ_MEM) |
                  (insn_op == `CSU_OP_CNE_MEM) |
                  (insn_op == `CSU_OP_CNE_IMM);
  assign is_imm = (insn_op == `CSU_OP_CEQ_IMM) |
                  (insn_op == `CSU_OP_CNE_IMM);
  assign is_test = (insn_op == `CSU_OP_TLO_IO) |
                   (insn_op == `CSU_OP_THI_IO) |
                   (insn_op == `CSU_OP_TLO_MEM) |
                   (insn_op == `CSU_OP_THI_MEM);
  assign is_step = (insn_op == `CSU_OP_INC_WR) |
                   (insn_op == `CSU_OP_DEC_WR) |
                   (insn_op == `CSU_OP_INC_MEM) |
                   (insn_op == `CSU_OP_DEC_MEM);
  assign step_mem = (insn_op == `CSU_OP_INC_MEM) |
                    (insn_op == `CSU_OP_DEC_MEM);
  assign step_dec = (insn_op == `CSU_OP_DEC_WR) |
                    (insn_op == `CSU_OP_DEC_MEM);
  assign test_io = (insn_op == `CSU_OP_TLO_IO) |
                   (insn_op == `CSU_OP_THI_IO);
  assign test_high = (insn_op == `CSU_OP_THI_IO) |
                     (insn_op == `CSU_OP_THI_MEM);

  assign cmp_operand = is_imm ? insn_imm : mem_rdata;
  assign test_byte = test_io ? port_rdata : mem_rdata;
  // Bit index selects from the port or the memory byte
  assign test_bit = test_byte[insn_bit];

  ////////////////////////////////////////////////////////////////////////
  // Arithmetic: compare subtracts, step adds or subtracts one
  wire [7:0] alu_a;
  wire [7:0] alu_b;
  wire alu_sub;
  wire [7:0] alu_res;
  wire [3:0] alu_flags;

  assign alu_a = is_cmp ? work_ff : (step_mem ? mem_rdata : work_ff);
  assign alu_b = is_cmp ? cmp_operand : 8'h01;
  assign alu_sub = is_cmp | step_dec;

  csu_arith u_arith
  (
    .opa(alu_a),
    .opb(alu_b),
    .sub(alu_sub),
    .result(alu_res),
    .flags(alu_flags)
  );

  ////////////////////////////////////////////////////////////////////////
  // Skip decision
  reg take_skip;

  // Steps skip on the value written back, so the adder's zero flag
  // decides; bit tests never reach the flag path

  always @*
  begin
    take_skip = 1'b0;
    case (insn_op)
      `CSU_OP_CEQ_IMM:
        take_skip = (work_ff == insn_imm);
      `CSU_OP_CEQ_MEM:
        take_skip = (work_ff == mem_rdata);
      `CSU_OP_CNE_MEM:
        take_skip = (work_ff != mem_rdata);
      `CSU_OP_CNE_IMM:
        take_skip = (work_ff != insn_imm);
      `CSU_OP_TLO_IO:
        take_skip = ~test_bit;
      `CSU_OP_THI_IO:
        take_skip = test_bit;
      `CSU_OP_TLO_MEM:
        take_skip = ~test_bit;
      `CSU_OP_THI_MEM:
        take_skip = test_bit;
      `CSU_OP_INC_WR,
      `CSU_OP_DEC_WR:
        take_skip = alu_flags[`CSU_FLAG_ZERO];
      `CSU_OP_INC_MEM,
      `CSU_OP_DEC_MEM:
        take_skip = alu_flags[`CSU_FLAG_ZERO];
      default:
        take_skip = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Register bus
  wire wr_ctrl;
  wire wr_work;
  wire wr_flags;
  wire [15:0] status_q;

  // Squash count above the enable and pending bits
  assign status_q = {skip_cnt_ff, 6'h00, enabled, state_ff == ST_SKIP};

  csu_wb_slave u_wb
  (
    .clock(clock),
    .rstn(rstn),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o),
    .ctrl_q(ctrl_ff),
    .work_q(work_ff),
    .flags_q(flags_ff),
    .status_q(status_q),
    .wr_ctrl(wr_ctrl),
    .wr_work(wr_work),
    .wr_flags(wr_flags)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic; an executing instruction wins over a bus write
  // Bus writes are applied first and then overridden by execution
  always @*
  begin
    nxt_state = state_ff;
    nxt_work = work_ff;
    nxt_flags = flags_ff;
    nxt_ctrl = ctrl_ff;
    nxt_skip_cnt = skip_cnt_ff;
    nxt_mem_we = 1'b0;
    nxt_mem_wdata = mem_wdata_ff;

    if (wr_ctrl)
      nxt_ctrl = {1'b0, wb_dat_i[`CSU_CTRL_ENABLE]};
    if (wr_ctrl && wb_dat_i[`CSU_CTRL_CNT_CLR])
      nxt_skip_cnt = 8'h00;
    if (wr_work)
      nxt_work = wb_dat_i[7:0];
    if (wr_flags)
      nxt_flags = wb_dat_i[3:0];

    case (state_ff)
      ST_RUN:
      begin
        if (live)
        begin
          if (is_cmp)
            nxt_flags = alu_flags;
          if (is_step)
            nxt_flags = alu_flags;
          if (is_step && !step_mem)
            nxt_work = alu_res;
          if (is_step && step_mem)
          begin
            nxt_mem_we = 1'b1;
            nxt_mem_wdata = alu_res;
          end
          if (take_skip)
            nxt_state = ST_SKIP;
        end
      end
      ST_SKIP:
      begin
        // Next instruction is consumed with no effect
        if (insn_valid)
        begin
          nxt_state = ST_RUN;
          // Builds on a same-cycle clear, so the count restarts at one
          // rather than losing this squash
          nxt_skip_cnt = nxt_skip_cnt + 8'h01;
        end
      end
      default:
        nxt_state = ST_RUN;
    endcase
  end

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff <= ST_RUN;
      work_ff <= `CSU_RST_WORK;
      flags_ff <= `CSU_RST_FLAGS;
      ctrl_ff <= `CSU_RST_CTRL;
      skip_cnt_ff <= 8'h00;
      mem_we_ff <= 1'b0;
      mem_wdata_ff <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      work_ff <= nxt_work;
      flags_ff <= nxt_flags;
      ctrl_ff <= nxt_ctrl;
      skip_cnt_ff <= nxt_skip_cnt;
      mem_we_ff <= nxt_mem_we;
      mem_wdata_ff <= nxt_mem_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  // Squash is combinational so the sequencer can cancel the fetched
  // operation in the cycle it is offered
  assign skip_pending = (state_ff == ST_SKIP);
  assign insn_squash = insn_valid & (state_ff == ST_SKIP);
  assign working_register = work_ff;
  assign flags = flags_ff;

endmodule // csu_skip_unit

// file: csu_skip_unit_sva.sv
// Assertions on the ports of csu_skip_unit.
// Assumes the control enable bit stays set.
`timescale 1ns/1ps
`include "csu_defines.vh"
module csu_skip_unit_sva
(
  input wire clock,
  input wire rstn,
  input wire insn_valid,
  input wire [3:0] insn_op,
  input wire [7:0] insn_imm,
  input wire [2:0] insn_bit,
  input wire [7:0] mem_rdata,
  input wire [7:0] port_rdata,
  input wire insn_squash,
  input wire skip_pending,
  input wire mem_we_ff,
  input wire [7:0] mem_wdata_ff,
  input wire [7:0] working_register,
  input wire [3:0] flags,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire wb_ack_o
);
  wire go = insn_valid && !skip_pending;
  wire bw = wb_cyc_i && wb_stb_i && wb_we_i;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////////////////////////
  squash_level_a: assert property (
    insn_squash == (insn_valid && skip_pending)) else $error("bad squash");
  squash_effect_a: assert property (
    insn_squash && !bw |=> !skip_pending && !mem_we_ff && $stable(flags)
    && $stable(working_register)) else $error("squash side effect");
  bit_flags_a: assert property (
    go && insn_op[3:2] == 2'b01 && !bw |=> $stable(flags))
    else $error("bit test moved flags");
  port_high_a: assert property (
    go && insn_op == `CSU_OP_THI_IO && port_rdata[insn_bit] |=> skip_pending)
    else $error("port high no skip");
  ceq_imm_a: assert property (
    go && insn_op == `CSU_OP_CEQ_IMM && insn_imm == working_register
    |=> skip_pending && flags[`CSU_FLAG_ZERO]) else $error("ceq imm");
  cne_mem_a: assert property (
    go && insn_op == `CSU_OP_CNE_MEM |=> skip_pending
    != flags[`CSU_FLAG_ZERO]) else $error("cne mem");
  cmp_keep_a: assert property (
    go && insn_op[3:2] == 2'b00 && !bw |=> $stable(working_register))
    else $error("compare wrote back");
  inc_mem_a: assert property (
    go && insn_op == `CSU_OP_INC_MEM |=> mem_we_ff && mem_wdata_ff ==
    $past(mem_rdata) + 8'h01 && skip_pending == (mem_wdata_ff == 8'h00))
    else $error("inc mem");
  dec_mem_a: assert property (
    go && insn_op == `CSU_OP_DEC_MEM |=> mem_we_ff && mem_wdata_ff ==
    $past(mem_rdata) - 8'h01 && skip_pending == (mem_wdata_ff == 8'h00))
    else $error("dec mem");
  dec_work_a: assert property (
    go && insn_op == `CSU_OP_DEC_WR && !bw |=> working_register ==
    $past(working_register) - 8'h01 && skip_pending ==
    (working_register == 8'h00)) else $error("dec work");
  bus_ack_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing");
  cover property (insn_squash);
  cover property (go && insn_op == `CSU_OP_INC_MEM ##1 skip_pending);
  cover property (wb_ack_o && !wb_we_i);
endmodule // csu_skip_unit_sva

bind csu_skip_unit csu_skip_unit_sva u_csu_skip_unit_sva (.clock(clock),
  .rstn(rstn), .insn_valid(insn_valid), .insn_op(insn_op),
  .insn_imm(insn_imm), .insn_bit(insn_bit), .mem_rdata(mem_rdata),
  .port_rdata(port_rdata), .insn_squash(insn_squash),
  .skip_pending(skip_pending), .mem_we_ff(mem_we_ff),
  .mem_wdata_ff(mem_wdata_ff), .working_register(working_register),
  .flags(flags), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o));

// file: csu_mem_model.sv
// Data memory byte and port register facing the skip unit.
// Assumes preloads happen only between instructions.
`timescale 1ns/1ps
module csu_mem_model
(
  input wire clock,
  input wire load,
  input wire [7:0] load_data,
  input wire [7:0] port_value,
  input wire mem_we,
  input wire [7:0] mem_wdata,
  output wire [7:0] mem_rdata,
  output wire [7:0] port_rdata
);
  reg [7:0] mem_ff = 8'h00;
  // Forward a write-back still in flight
  assign mem_rdata = mem_we ? mem_wdata : mem_ff;
  assign port_rdata = port_value;
  always @(posedge clock)
  begin
    if (load)
      mem_ff <= load_data;
    else if (mem_we)
      mem_ff <= mem_wdata;
  end
endmodule // csu_mem_model

// file: testbench.sv
// Self-checking bench for csu_skip_unit with a memory model.
// Assumes one clock; control enable stays set.
`timescale 1ns/1ps
`include "csu_defines.vh"
module testbench;
  reg clock = 1'b0;
  reg rstn = 1'b0;
  reg insn_valid = 1'b0;
  reg [3:0] insn_op = 4'h0;
  reg [7:0] insn_imm = 8'h00;
  reg [2:0] insn_bit = 3'h0;
  reg cyc = 1'b0;
  reg we = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [31:0] dat = 32'h0000_0000;
  reg [3:0] sel = 4'hf;
  reg load = 1'b0;
  reg [7:0] ld = 8'h00;
  reg [7:0] pv = 8'h00;
  reg vld_d = 1'b0;
  wire [7:0] mrd, prd, wr_o, mwd;
  wire [3:0] fl_o;
  wire sq, sp_o, mwe, ack;
  wire [31:0] rd;
  integer seed = 32'ha33150a8;
  integer bad_count = 0;
  integer num_checks = 0;
  integer i;
  reg [31:0] r;
  reg [21:0] e;
  reg sp = 1'b0;
  reg [3:0] fl = 4'h0;
  reg [7:0] wr = 8'h00;
  reg [7:0] mv = 8'h00;
  reg [7:0] nsq = 8'h00;
  reg [21:0] qi[$];
  reg [31:0] qb[$];
  reg qs[$];
  csu_skip_unit u_csu_skip_unit (.clock(clock), .rstn(rstn),
    .insn_valid(insn_valid), .insn_op(insn_op), .insn_imm(insn_imm),
    .insn_bit(insn_bit), .mem_rdata(mrd), .port_rdata(prd),
    .insn_squash(sq), .skip_pending(sp_o), .mem_we_ff(mwe),
    .mem_wdata_ff(mwd), .working_register(wr_o), .flags(fl_o),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(rd));
  csu_mem_model u_csu_mem_model (.clock(clock), .load(load),
    .load_data(ld), .port_value(pv), .mem_we(mwe), .mem_wdata(mwd),
    .mem_rdata(mrd), .port_rdata(prd));
  initial
  begin
    forever #12.5 clock = ~clock;
  end
  //////////////////////////////////////////////////////////////////////
  task check(input [31:0] seen, input [31:0] exp);
  begin
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED at %0t: %h vs %h", $time, seen, exp);
    end
  end
  endtask
  task tally_and_finish;
  begin
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  // Flags {wrap, nibble, carry, zero} and result
  function [11:0] alu(input [7:0] a, input [7:0] b, input s);
    reg [8:0] t;
    reg [4:0] n;
  begin
    t = s ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    n = s ? {1'b0, a[3:0]} - {1'b0, b[3:0]} : {1'b0, a[3:0]} + b[3:0];
    alu = {a[7] == (b[7] ^ s) && t[7] != a[7], n[4], t[8],
      t[7:0] == 8'h00, t[7:0]};
  end
  endfunction
  task ex(input [3:0] op, input [7:0] imm, input [2:0] b, input [7:0] p);
    reg [11:0] t;
    reg tk;
    reg [8:0] w;
  begin
    insn_valid <= 1'b1;
    insn_op <= op;
    insn_imm <= imm;
    insn_bit <= b;
    pv <= p;
    tk = 1'b0;
    w = 9'h000;
    if (sp)
      nsq = nsq + 8'h01;
    else
    begin
      case (op)
        4'h0, 4'h3: t = alu(wr, imm, 1'b1);
        4'h1, 4'h2: t = alu(wr, mv, 1'b1);
        4'h8, 4'h9: t = alu(wr, 8'h01, op[0]);
        default: t = alu(mv, 8'h01, op[0]);
      endcase
      case (op)
        4'h2, 4'h3: tk = t[7:0] != 8'h00;
        4'h4: tk = !p[b];
        4'h5: tk = p[b];
        4'h6: tk = !mv[b];
        4'h7: tk = mv[b];
        4'hc, 4'hd, 4'he, 4'hf: tk = 1'b0;
        default: tk = t[7:0] == 8'h00;
      endcase
      if (op < 4'h4 || (op > 4'h7 && op < 4'hc))
        fl = t[11:8];
      if (op[3:1] == 3'b100)
        wr = t[7:0];
      if (op[3:1] == 3'b101)
      begin
        mv = t[7:0];
        w = {1'b1, t[7:0]};
      end
    end
    qs.push_back(sp);
    sp = tk;
    qi.push_back({sp, fl, wr, w});
    @(posedge clock);
  end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
  begin
    insn_valid <= 1'b0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clock);
    while (ack !== 1'b1)
      @(posedge clock);
    cyc <= 1'b0;
    @(posedge clock);
  end
  endtask
  task rdc(input [7:0] a, input [31:0] x);
  begin
    qb.push_back(x);
    bus(1'b0, a, 32'h0000_0000);
  end
  endtask
  //////////////////////////////////////////////////////////////////////
  always @(posedge clock)
  begin
    vld_d <= insn_valid;
    if (insn_valid)
      check(sq, qs.pop_front());
    if (vld_d)
    begin
      e = qi.pop_front();
      check(sp_o, e[21]);
      check(fl_o, e[20:17]);
      check({wr_o, mwe, mwe ? mwd : 8'h00}, e[16:0]);
    end
    if (ack && !we)
      check(rd, qb.pop_front());
  end
  initial
  begin
    #(25 * 20000);
    bad_count = bad_count + 1;
    tally_and_finish;
  end
  initial
  begin
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rdc(`CSU_REG_CTRL, 32'h0000_0001);
    rdc(`CSU_REG_WORK, 32'h0000_0000);
    rdc(`CSU_REG_FLAGS, 32'h0000_0000);
    bus(1'b1, 8'h10, 32'hffff_ffff);
    rdc(8'h10, 32'h0000_0000);
    sel <= 4'he;
    bus(1'b1, `CSU_REG_WORK, 32'h0000_00a5);
    sel <= 4'hf;
    rdc(`CSU_REG_WORK, 32'h0000_0000);
    for (i = 0; i < 512; i = i + 1)
    begin
      r = $random(seed);
      if (i % 16 == 0)
      begin
        bus(1'b1, `CSU_REG_STATUS, 32'hffff_ffff);
        rdc(`CSU_REG_STATUS, {16'h0000, nsq, 6'h00, 1'b1, sp});
        bus(1'b1, `CSU_REG_CTRL, 32'h0000_0003);
        nsq = 8'h00;
        wr = i[5] ? (i[4] ? 8'hff : 8'h80) : (i[4] ? 8'h7f : 8'h01);
        fl = r[3:0];
        bus(1'b1, `CSU_REG_WORK, {24'h00_0000, wr});
        bus(1'b1, `CSU_REG_FLAGS, {28'h000_0000, fl});
        rdc(`CSU_REG_FLAGS, {28'h000_0000, fl});
      end
      if (i % 8 == 4)
      begin
        mv = i[3] ? wr : (i[5] ? 8'hff : r[15:8]);
        insn_valid <= 1'b0;
        load <= 1'b1;
        ld <= mv;
        @(posedge clock);
        load <= 1'b0;
      end
      ex(i < 32 ? i[3:0] : r[3:0], r[4] ? wr : r[31:24], r[7:5], r[23:16]);
    end
    rdc(`CSU_REG_STATUS, {16'h0000, nsq, 6'h00, 1'b1, sp});
    tally_and_finish;
  end
endmodule // testbench
